/* core/scm_map.vh */
// constants for the serial command-mode interpreter
`ifndef SCM_MAP_VH
`define SCM_MAP_VH
// apb register byte offsets
`define SCM_OFF_CTRL    12'h000
`define SCM_OFF_STATUS  12'h004
`define SCM_OFF_CFG0    12'h008
`define SCM_OFF_CFG1    12'h00C
// field positions
`define SCM_CTRL_DET    0
`define SCM_CTRL_EXIT   1
`define SCM_ST_CMD      0
`define SCM_ST_PEND     1
`define SCM_ST_RESP     2
// reset values of settings
`define SCM_RST_GT      16'h03E8
`define SCM_RST_CC      8'h2B
`define SCM_RST_CT      16'h0064
`define SCM_RST_BD      4'h3
`define SCM_BD_MAX      4'h8
// timing
`define SCM_CLK_HZ      10000000
`define SCM_TICK_MS     1
`define SCM_CT_UNIT_MS  7'h64
`define SCM_ESC_COUNT   2'h3
// characters
`define SCM_CH_A        8'h41
`define SCM_CH_T        8'h54
`define SCM_CH_X        8'h58
`define SCM_CH_0        8'h30
`define SCM_CH_CR       8'h0D
`define SCM_CH_COMMA    8'h2C
`define SCM_CH_SP       8'h20
// command codes, two upper-case letters
`define SCM_CMD_GT      16'h4754
`define SCM_CMD_CC      16'h4343
`define SCM_CMD_CT      16'h4354
`define SCM_CMD_BD      16'h4244
`define SCM_CMD_AC      16'h4143
`define SCM_CMD_WR      16'h5752
`define SCM_CMD_CN      16'h434E
// responses, first character in the top byte
`define SCM_RSP_OK      48'h4F4B_0D00_0000
`define SCM_RSP_ERR     48'h4552_524F_520D
`define SCM_LEN_OK      3'h3
`define SCM_LEN_ERR     3'h6
`define SCM_LEN_VAL     3'h5
// baud rates in b/s
`define SCM_BAUD0       1200
`define SCM_BAUD1       2400
`define SCM_BAUD2       4800
`define SCM_BAUD3       9600
`define SCM_BAUD4       19200
`define SCM_BAUD5       38400
`define SCM_BAUD6       57600
`define SCM_BAUD7       115200
`define SCM_BAUD8       230400
`endif

/* core/scm_tick.v */
// millisecond tick generator
`timescale 1ns/100ps
module scm_tick #(
	parameter MS_CYCLES = 10000
) (
	input  wire        clk,
	input  wire        reset,
	input  wire        ce,
	output reg         tick_r
);
	reg [23:0] cnt_r;

	always @(posedge clk) begin
		if (reset) begin
			cnt_r  <= 24'h00_0000;
			tick_r <= 1'b0;
		end else if (ce) begin
			if (cnt_r == MS_CYCLES[23:0] - 24'h00_0001) begin
				cnt_r  <= 24'h00_0000;
				tick_r <= 1'b1;
			end else begin
				cnt_r  <= cnt_r + 24'h00_0001;
				tick_r <= 1'b0;
			end
		end
	end
endmodule // scm_tick

/* core/scm_interp.v */
// serial command-mode interpreter with apb status and configuration
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - enter only after guard silence, three escape chars, guard silence
// - in command mode stop forwarding, interpret characters locally
// - send OK on entry, after earlier serial data has drained
// - idle timeout with no input leaves command mode
// - escape detection looks only at the uart receive path
// - command mode works in transparent and api framing alike
// - a line is AT, two-letter code, optional parameter
// - a command without parameter returns its current value
// - reply OK on success, ERROR on failure
// - commas separate several commands after one AT, run in order
// - hex parameters accepted bare or with 0x prefix
// - writes stay pending until apply command or leaving command mode
// - persist command stores settings; reset restores stored ones
// - exit command ended by carriage return leaves command mode
// - baud code 7 gives 115200, default code 3 gives 9600
// - guard time, escape char, idle timeout are settings
// - escape character defaults to plus sign
// - guard setting defaults to one second
// - idle timeout setting defaults to ten seconds
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
`include "scm_map.vh"
module scm_interp #(
	parameter MS_CYCLES = `SCM_CLK_HZ / 1000 * `SCM_TICK_MS
) (
	input  wire        clk,
	input  wire        reset,
	input  wire        ce,
	input  wire [11:0] paddr,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata_r,
	output reg         pready_r,
	output reg         pslverr_r,
	input  wire        rx_valid,
	input  wire [7:0]  rx_data,
	output reg         rx_ready_r,
	input  wire        tx_busy,
	output reg         tx_valid_r,
	output reg  [7:0]  tx_data_r,
	input  wire        tx_ready,
	output reg         fwd_valid_r,
	output reg  [7:0]  fwd_data_r,
	input  wire [15:0] nv_guard,
	input  wire [7:0]  nv_escape,
	input  wire [15:0] nv_timeout,
	input  wire [3:0]  nv_baud,
	output reg         nv_write_r,
	output reg  [43:0] nv_wdata_r,
	output reg         command_mode_r,
	output reg  [3:0]  baud_select_r,
	output reg  [15:0] baud_div_r
);
	localparam P_A = 3'd0, P_T = 3'd1, P_C1 = 3'd2, P_C2 = 3'd3, P_PAR = 3'd4, P_SKIP = 3'd5;

	function [4:0] hexval; // {valid, nibble}
		input [7:0] c;
		begin
			if (c >= 8'h30 && c <= 8'h39)
				hexval = {1'b1, c[3:0]};
			else if (c >= 8'h41 && c <= 8'h46)
				hexval = {1'b1, c[3:0] + 4'h9};
			else
				hexval = 5'h00;
		end
	endfunction

	function [7:0] upcase;
		input [7:0] c;
		begin
			upcase = (c >= 8'h61 && c <= 8'h7A) ? c - 8'h20 : c;
		end
	endfunction

	function [7:0] hexchar;
		input [3:0] n;
		begin
			hexchar = (n < 4'hA) ? {4'h3, n} : {4'h4, n - 4'h9};
		end
	endfunction

	function [15:0] baud_div; // clock cycles per bit
		input [3:0] code;
		reg [31:0] r;
		reg [31:0] q;
		begin
			case (code)
				4'h0: r = `SCM_BAUD0;
				4'h1: r = `SCM_BAUD1;
				4'h2: r = `SCM_BAUD2;
				4'h3: r = `SCM_BAUD3;
				4'h4: r = `SCM_BAUD4;
				4'h5: r = `SCM_BAUD5;
				4'h6: r = `SCM_BAUD6;
				4'h7: r = `SCM_BAUD7;
				default: r = `SCM_BAUD8;
			endcase
			q        = `SCM_CLK_HZ / r;
			baud_div = q[15:0];
		end
	endfunction

	wire        ms_tick;
	reg         load_r, det_en_r, exit_req_r;
	reg  [15:0] gt_p_r, ct_p_r, gt_a_r, ct_a_r;
	reg  [7:0]  cc_p_r, cc_a_r;
	reg  [3:0]  bd_p_r;
	reg  [15:0] sil_r, idle_r;
	reg  [6:0]  sub_r;
	reg  [1:0]  esc_r;
	reg         ok_wait_r;
	reg  [2:0]  pst_r;
	reg  [15:0] code_r, val_r;
	reg  [2:0]  ndig_r;
	reg         has_r, bad_r, pfx_r;
	reg  [47:0] rsp_r;
	reg  [2:0]  rlen_r;
	reg         leave_r;
	reg  [7:0]  ch;
	reg         ok;
	reg  [15:0] rd;
	reg         rdv;

	scm_tick #(.MS_CYCLES(MS_CYCLES)) u_tick (
		.clk    (clk),
		.reset  (reset),
		.ce     (ce),
		.tick_r (ms_tick)
	);

	wire take    = rx_valid & rx_ready_r;
	wire pending = (gt_p_r != gt_a_r) | (cc_p_r != cc_a_r) | (ct_p_r != ct_a_r)
		| (bd_p_r != baud_select_r);
	wire apb_wr  = psel & penable & pwrite;
	wire idle_to = command_mode_r & (idle_r >= ct_a_r);
	wire [4:0] hv = hexval(upcase(rx_data));

	// command evaluation of the parsed code and parameter
	always @* begin
		ch  = upcase(rx_data);
		ok  = ~bad_r;
		rd  = 16'h0000;
		rdv = 1'b0;
		case (code_r)
			`SCM_CMD_GT: begin rd = gt_p_r; rdv = ~has_r; end
			`SCM_CMD_CT: begin rd = ct_p_r; rdv = ~has_r; end
			`SCM_CMD_CC: begin
				rd = {8'h00, cc_p_r};
				rdv = ~has_r;
				ok = ok & (val_r[15:8] == 8'h00);
			end
			`SCM_CMD_BD: begin
				rd = {12'h000, bd_p_r};
				rdv = ~has_r;
				ok = ok & (val_r <= {12'h000, `SCM_BD_MAX});
			end
			`SCM_CMD_AC, `SCM_CMD_WR, `SCM_CMD_CN: ok = ok & ~has_r;
			default: ok = 1'b0;
		endcase
	end

	//////////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		if (reset) begin
			load_r         <= 1'b1;
			det_en_r       <= 1'b1;
			exit_req_r     <= 1'b0;
			gt_p_r         <= `SCM_RST_GT;
			gt_a_r         <= `SCM_RST_GT;
			cc_p_r         <= `SCM_RST_CC;
			cc_a_r         <= `SCM_RST_CC;
			ct_p_r         <= `SCM_RST_CT;
			ct_a_r         <= `SCM_RST_CT;
			bd_p_r         <= `SCM_RST_BD;
			baud_select_r  <= `SCM_RST_BD;
			baud_div_r     <= baud_div(`SCM_RST_BD);
			sil_r          <= 16'h0000;
			idle_r         <= 16'h0000;
			sub_r          <= 7'h00;
			esc_r          <= 2'h0;
			ok_wait_r      <= 1'b0;
			command_mode_r <= 1'b0;
			pst_r          <= P_A;
			code_r         <= 16'h0000;
			val_r          <= 16'h0000;
			ndig_r         <= 3'h0;
			has_r          <= 1'b0;
			bad_r          <= 1'b0;
			pfx_r          <= 1'b0;
			rsp_r          <= 48'h0000_0000_0000;
			rlen_r         <= 3'h0;
			leave_r        <= 1'b0;
			rx_ready_r     <= 1'b0;
			tx_valid_r     <= 1'b0;
			tx_data_r      <= 8'h00;
			fwd_valid_r    <= 1'b0;
			fwd_data_r     <= 8'h00;
			nv_write_r     <= 1'b0;
			nv_wdata_r     <= 44'h000_0000_0000;
			prdata_r       <= 32'h0000_0000;
			pready_r       <= 1'b0;
			pslverr_r      <= 1'b0;
		end else if (ce) begin
			nv_write_r  <= 1'b0;
			fwd_valid_r <= 1'b0;
			pready_r    <= psel & ~penable;
			// error flag stands only beside ready, never on an idle bus
			pslverr_r   <= 1'b0;
			// settings come back from storage after every reset
			if (load_r) begin
				load_r        <= 1'b0;
				gt_p_r        <= nv_guard;
				gt_a_r        <= nv_guard;
				cc_p_r        <= nv_escape;
				cc_a_r        <= nv_escape;
				ct_p_r        <= nv_timeout;
				ct_a_r        <= nv_timeout;
				bd_p_r        <= nv_baud;
				baud_select_r <= nv_baud;
				baud_div_r    <= baud_div(nv_baud);
			end
			// apb slave: no wait state, answer in first access cycle
			if (psel & ~penable) begin
				case (paddr)
					`SCM_OFF_CTRL:   prdata_r <= {30'h0000_0000, exit_req_r, det_en_r};
					`SCM_OFF_STATUS: prdata_r <= {29'h0000_0000, (rlen_r != 3'h0),
						pending, command_mode_r};
					`SCM_OFF_CFG0:   prdata_r <= {ct_a_r, gt_a_r};
					`SCM_OFF_CFG1:   prdata_r <= {20'h0_0000, baud_select_r, cc_a_r};
					default: begin
						prdata_r  <= 32'h0000_0000;
						pslverr_r <= 1'b1;
					end
				endcase
			end
			if (apb_wr & pready_r & (paddr == `SCM_OFF_CTRL)) begin
				det_en_r   <= pwdata[`SCM_CTRL_DET];
				exit_req_r <= pwdata[`SCM_CTRL_EXIT];
			end
			// silence and idle counters restart on any char
			if (take) begin
				sil_r  <= 16'h0000;
				idle_r <= 16'h0000;
				sub_r  <= 7'h00;
			end else if (ms_tick) begin
				if (sil_r != 16'hFFFF)
					sil_r <= sil_r + 16'h0001;
				if (sub_r == `SCM_CT_UNIT_MS - 7'h01) begin
					sub_r <= 7'h00;
					if (idle_r != 16'hFFFF)
						idle_r <= idle_r + 16'h0001;
				end else begin
					sub_r <= sub_r + 7'h01;
				end
			end
			// response shifter; a new char is loaded when tx_valid_r is low or tx_ready takes the last
			if (rlen_r != 3'h0 && !ok_wait_r && (!tx_valid_r || tx_ready)) begin
				tx_valid_r <= 1'b1;
				tx_data_r  <= rsp_r[47:40];
				rsp_r      <= {rsp_r[39:0], 8'h00};
				rlen_r     <= rlen_r - 3'h1;
			end else if (tx_ready) begin
				tx_valid_r <= 1'b0;
			end
			// ok waits for earlier data to leave the transmitter
			if (ok_wait_r && !tx_busy)
				ok_wait_r <= 1'b0;
			rx_ready_r <= ~load_r & (rlen_r == 3'h0) & ~ok_wait_r & ~leave_r;
			if (!command_mode_r) begin
				// detector on the uart stream only, any framing mode
				if (take) begin
					fwd_valid_r <= 1'b1;
					fwd_data_r  <= rx_data;
					if (rx_data == cc_a_r && det_en_r && esc_r != `SCM_ESC_COUNT
						&& (esc_r != 2'h0 || sil_r >= gt_a_r))
						esc_r <= esc_r + 2'h1;
					else
						esc_r <= 2'h0;
				end else if (esc_r == `SCM_ESC_COUNT && sil_r >= gt_a_r) begin
					command_mode_r <= 1'b1;
					esc_r          <= 2'h0;
					idle_r         <= 16'h0000;
					sub_r          <= 7'h00;
					pst_r          <= P_A;
					ok_wait_r      <= 1'b1;
					rsp_r          <= `SCM_RSP_OK;
					rlen_r         <= `SCM_LEN_OK;
				end
			end else if ((leave_r && rlen_r == 3'h0 && !tx_valid_r) || idle_to
				|| exit_req_r) begin
				// leaving applies pending writes
				command_mode_r <= 1'b0;
				leave_r        <= 1'b0;
				exit_req_r     <= 1'b0;
				gt_a_r         <= gt_p_r;
				cc_a_r         <= cc_p_r;
				ct_a_r         <= ct_p_r;
				baud_select_r  <= bd_p_r;
				baud_div_r     <= baud_div(bd_p_r);
			end else if (take) begin
				case (pst_r)
					P_A: pst_r <= (ch == `SCM_CH_A) ? P_T : P_SKIP;
					P_T: pst_r <= (ch == `SCM_CH_T) ? P_C1 : P_SKIP;
					P_C1: begin
						if (ch == `SCM_CH_CR) begin
							pst_r  <= P_A;
							rsp_r  <= `SCM_RSP_OK; // bare AT
							rlen_r <= `SCM_LEN_OK;
						end else begin
							code_r[15:8] <= ch;
							pst_r        <= P_C2;
						end
					end
					P_C2: begin
						code_r[7:0] <= ch;
						val_r       <= 16'h0000;
						ndig_r      <= 3'h0;
						has_r       <= 1'b0;
						bad_r       <= 1'b0;
						pfx_r       <= 1'b0;
						pst_r       <= P_PAR;
					end
					P_PAR: begin
						if (ch == `SCM_CH_CR || ch == `SCM_CH_COMMA) begin
							pst_r <= (ch == `SCM_CH_COMMA) ? P_C1 : P_A;
							if (!ok) begin
								rsp_r  <= `SCM_RSP_ERR;
								rlen_r <= `SCM_LEN_ERR;
							end else if (rdv) begin
								rsp_r  <= {hexchar(rd[15:12]), hexchar(rd[11:8]),
									hexchar(rd[7:4]), hexchar(rd[3:0]), `SCM_CH_CR,
									8'h00};
								rlen_r <= `SCM_LEN_VAL;
							end else begin
								rsp_r  <= `SCM_RSP_OK;
								rlen_r <= `SCM_LEN_OK;
								case (code_r)
									`SCM_CMD_GT: gt_p_r <= val_r;
									`SCM_CMD_CT: ct_p_r <= val_r;
									`SCM_CMD_CC: cc_p_r <= val_r[7:0];
									`SCM_CMD_BD: bd_p_r <= val_r[3:0];
									`SCM_CMD_AC: begin
										gt_a_r        <= gt_p_r;
										cc_a_r        <= cc_p_r;
										ct_a_r        <= ct_p_r;
										baud_select_r <= bd_p_r;
										baud_div_r    <= baud_div(bd_p_r);
									end
									`SCM_CMD_WR: begin
										nv_write_r <= 1'b1;
										nv_wdata_r <= {bd_p_r, ct_p_r, cc_p_r, gt_p_r};
									end
									`SCM_CMD_CN: leave_r <= (ch == `SCM_CH_CR);
									default: rlen_r <= `SCM_LEN_OK;
								endcase
							end
						end else if (ch == `SCM_CH_SP && !has_r) begin
							has_r <= 1'b0; // space before the value is allowed
						end else if (ch == `SCM_CH_X && !pfx_r && ndig_r == 3'h1
							&& val_r == 16'h0000) begin
							pfx_r  <= 1'b1;
							ndig_r <= 3'h0;
						end else if (hv[4] && ndig_r != 3'h4) begin
							val_r  <= {val_r[11:0], hv[3:0]};
							ndig_r <= ndig_r + 3'h1;
							has_r  <= 1'b1;
						end else begin
							bad_r <= 1'b1;
							has_r <= 1'b1;
						end
					end
					P_SKIP: begin
						if (ch == `SCM_CH_CR) begin
							pst_r  <= P_A;
							rsp_r  <= `SCM_RSP_ERR;
							rlen_r <= `SCM_LEN_ERR;
						end
					end
					default: pst_r <= P_A;
				endcase
			end
		end
	end
endmodule // scm_interp

/* verification/scm_interp_assertions.sv */
// assertions on the ports of the command-mode interpreter
`timescale 1ns/100ps
module scm_interp_chk (
	input wire        clk,
	input wire        reset,
	input wire        psel,
	input wire        penable,
	input wire        pready_r,
	input wire        pslverr_r,
	input wire        rx_valid,
	input wire [7:0]  rx_data,
	input wire        rx_ready_r,
	input wire        tx_busy,
	input wire        tx_valid_r,
	input wire [7:0]  tx_data_r,
	input wire        tx_ready,
	input wire        fwd_valid_r,
	input wire [7:0]  fwd_data_r,
	input wire        nv_write_r,
	input wire        command_mode_r,
	input wire [3:0]  baud_select_r,
	input wire [15:0] baud_div_r
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_take; rx_valid && rx_ready_r; endsequence
	sequence s_entry; $rose(command_mode_r); endsequence
	property p_rdy; psel && !penable |=> pready_r; endproperty
	a_rdy: assert property (p_rdy) else $error("no ready after setup");
	property p_rdy1; pready_r |=> !pready_r; endproperty
	a_rdy1: assert property (p_rdy1) else $error("ready longer than one cycle");
	property p_err; pslverr_r |-> pready_r; endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_fwd; s_take ##0 !command_mode_r |=> fwd_valid_r && fwd_data_r == $past(rx_data); endproperty
	a_fwd: assert property (p_fwd) else $error("byte not forwarded");
	property p_nofwd; command_mode_r && $past(command_mode_r) |-> !fwd_valid_r; endproperty
	a_nofwd: assert property (p_nofwd) else $error("forward in command mode");
	property p_ok; s_entry ##0 !tx_busy |-> ##[0:8] tx_valid_r && tx_data_r == 8'h4F; endproperty
	a_ok: assert property (p_ok) else $error("no prompt on entry");
	property p_okwait; s_entry ##0 tx_busy |-> !tx_valid_r; endproperty
	a_okwait: assert property (p_okwait) else $error("prompt while busy");
	property p_hold; tx_valid_r && !tx_ready |=> tx_valid_r && $stable(tx_data_r); endproperty
	a_hold: assert property (p_hold) else $error("reply byte not held");
	property p_nv; nv_write_r |=> !nv_write_r; endproperty
	a_nv: assert property (p_nv) else $error("store pulse too long");
	property p_bd; baud_select_r == 4'h3 |-> baud_div_r == 16'h0411; endproperty
	a_bd: assert property (p_bd) else $error("divider wrong for code 3");
endmodule // scm_interp_chk
bind scm_interp scm_interp_chk i_chk (.*);

/* verification/scm_host.sv */
// host-side sink that collects the interpreter's serial replies
`timescale 1ns/100ps
module scm_host (
	input  wire       clk,
	input  wire       reset,
	input  wire       slow,
	input  wire       tx_valid,
	input  wire [7:0] tx_data,
	output reg        tx_ready
);
	reg [7:0] got[$];
	// slow mode stalls every other cycle so the reply byte must be held
	always @(posedge clk) begin
		if (reset) begin
			tx_ready <= 1'b0;
		end else begin
			if (tx_valid && tx_ready) got.push_back(tx_data);
			tx_ready <= slow ? ~tx_ready : 1'b1;
		end
	end
endmodule // scm_host

/* verification/test_scm_interp.sv */
// self-checking bench for the command-mode interpreter
`timescale 1ns/100ps
`include "scm_map.vh"
module test_scm_interp;
	localparam GT = 16'h0014; // 20 ms guard, short for simulation
	localparam CT = 16'h0002; // 200 ms idle limit
	reg         clk = 0, reset = 1, ce = 1, psel = 0, penable = 0, pwrite = 0;
	reg  [11:0] paddr = 0;
	reg  [31:0] pwdata = 0;
	reg         rx_valid = 0, tx_busy = 0, slow = 0;
	reg  [7:0]  rx_data = 0, nv_escape = 8'h2B;
	reg  [15:0] nv_guard = GT, nv_timeout = CT;
	reg  [3:0]  nv_baud = 4'h3;
	wire [31:0] prdata_r;
	wire        pready_r, pslverr_r, rx_ready_r, tx_valid_r, tx_ready;
	wire        fwd_valid_r, nv_write_r, command_mode_r;
	wire [7:0]  tx_data_r, fwd_data_r;
	wire [43:0] nv_wdata_r;
	wire [3:0]  baud_select_r;
	wire [15:0] baud_div_r;
	reg  [43:0] nv_seen = 0;
	integer     miscompares = 0, checks = 0, nfwd = 0;
	scm_interp #(.MS_CYCLES(10)) i_scm_interp (.*);
	scm_host i_scm_host (.clk(clk), .reset(reset), .slow(slow), .tx_valid(tx_valid_r),
		.tx_data(tx_data_r), .tx_ready(tx_ready));
	always #50 clk = ~clk;
	// stand-in for the storage: only the stored baud code comes back after reset
	always @(posedge clk) begin
		if (fwd_valid_r) nfwd <= nfwd + 1;
		if (nv_write_r) nv_seen <= nv_wdata_r;
		if (nv_write_r) nv_baud <= nv_wdata_r[43:40];
	end
	//////////////////////////////////////////////////////////////////////////
	task final_report;
		if (miscompares == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task chk(input string nm, input [31:0] e, input [31:0] g);
		checks = checks + 1;
		if (g !== e) begin
			miscompares = miscompares + 1;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	task idle(input integer n);
		repeat (n) @(posedge clk);
	endtask
	task apb(input w, input [11:0] a, input [31:0] d, output [31:0] q, output e);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready_r !== 1'b1);
		q = prdata_r;
		e = pslverr_r;
		psel <= 0;
		penable <= 0;
		@(posedge clk);
	endtask
	task send(input [7:0] b);
		rx_valid <= 1;
		rx_data <= b;
		do @(posedge clk); while (rx_ready_r !== 1'b1);
		rx_valid <= 0;
		@(posedge clk);
	endtask
	task line(input string s);
		for (int i = 0; i < s.len(); i++) send(s[i]);
	endtask
	task reply(input string s);
		int n;
		n = 0;
		while (i_scm_host.got.size() < s.len() && n < 2000) begin
			@(posedge clk);
			n++;
		end
		chk("reply length", s.len(), i_scm_host.got.size());
		for (int i = 0; i < s.len(); i++) chk("reply byte", s[i], i_scm_host.got[i]);
		i_scm_host.got.delete();
	endtask
	task enter;
		idle(300);
		line("+++");
		idle(300);
	endtask
	//////////////////////////////////////////////////////////////////////////
	task t_regs;
		reg [31:0] q;
		reg        e;
		apb(0, `SCM_OFF_CFG0, 0, q, e);
		chk("cfg0", {CT, GT}, q);
		apb(0, `SCM_OFF_CFG1, 0, q, e);
		chk("cfg1", 32'h0000_032B, q);
		apb(1, 12'h010, 32'hFFFF_FFFF, q, e);
		chk("unmapped error", 1, e);
		apb(0, `SCM_OFF_CTRL, 0, q, e);
		chk("ctrl", 1, q);
	endtask
	task t_entry;
		send(8'h61);
		idle(300);
		line("+++\r");
		idle(300);
		chk("aborted entry", 0, command_mode_r);
		tx_busy <= 1;
		enter;
		chk("command mode", 1, command_mode_r);
		chk("prompt held", 0, i_scm_host.got.size());
		tx_busy <= 0;
		reply("OK\r");
		chk("forwarded", 8, nfwd);
	endtask
	task t_cmds;
		slow <= 1;
		line("ATBD7\r");
		reply("OK\r");
		chk("baud pending", 3, baud_select_r);
		line("ATAC\r");
		reply("OK\r");
		chk("baud applied", 7, baud_select_r);
		line("ATBD\r");
		reply("0007\r");
		line("ATBD0x5,WR,QQ\r");
		reply("OK\rOK\rERROR\r");
		chk("stored baud", 5, nv_seen[43:40]);
		chk("stored rest", {CT, 8'h2B, GT}, nv_seen[39:0]);
		chk("baud kept", 7, baud_select_r);
		line("ATCN\r");
		reply("OK\r");
		idle(5);
		chk("exit", 0, command_mode_r);
		chk("baud on exit", 5, baud_select_r);
		chk("no forward", 8, nfwd);
		slow <= 0;
	endtask
	task t_timeout;
		reset <= 1;
		idle(2);
		reset <= 0;
		idle(3);
		chk("baud restored", 5, baud_select_r);
		enter;
		reply("OK\r");
		idle(1600);
		chk("still command", 1, command_mode_r);
		idle(400);
		chk("timed out", 0, command_mode_r);
	endtask
	//////////////////////////////////////////////////////////////////////////
	initial begin
		#2_000_000;
		miscompares = miscompares + 1;
		final_report;
	end
	initial begin
		idle(2);
		reset <= 0;
		idle(2);
		t_regs;
		t_entry;
		t_cmds;
		t_timeout;
		final_report;
	end
endmodule // test_scm_interp
